// ---- logic/e3oi_pkg.sv ----
package e3oi_pkg;
    // overhead slot layout of one outbound frame
    localparam int OH_BITS = 12;
    localparam int POS_A = 10;
    localparam int POS_N = 11;
    localparam int FAS_BITS = 10;
    localparam int FRAME_BITS_DEF = 1536;
    localparam int CNT_W = 11;
    localparam int SYNC_W = 2;

    // terminal equipment pins, after the synchroniser
    typedef struct packed {
        logic ins;
        logic bit_val;
    } e3oi_te_in_t;

    // one held overhead bit
    typedef struct packed {
        logic valid;
        logic val;
    } e3oi_oh_bit_t;
endpackage : e3oi_pkg

// ---- logic/e3oi_pin_sync.sv ----
`timescale 1ns/1ps
module e3oi_pin_sync #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // asynchronous pins in, settled value out
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
    } e3oi_sync_t;

    e3oi_sync_t st_q;
    e3oi_sync_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // a change counts only once the second and third stages agree
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.stable[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_out = st_q.stable;
endmodule : e3oi_pin_sync

// ---- logic/e3oi_tx_overhead.sv ----
`timescale 1ns/1ps
module e3oi_tx_overhead
    import e3oi_pkg::*;
#(
    parameter int FRAME_BITS = FRAME_BITS_DEF
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // bit timing
    input wire logic transmit_line_clock,
    input wire logic receive_recovered_clock,
    input wire logic use_recovered_clock,
    // framer core stream
    input wire logic core_bit,
    output logic tx_line_bit,
    // terminal equipment port
    input wire logic overhead_bit_in,
    input wire logic overhead_insert_request,
    output logic overhead_slot_strobe,
    output logic overhead_frame_marker
);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(FRAME_BITS - 1);
    localparam logic [CNT_W-1:0] C_A = CNT_W'(POS_A);
    localparam logic [CNT_W-1:0] C_N = CNT_W'(POS_N);
    localparam logic [CNT_W-1:0] C_FAS = CNT_W'(FAS_BITS);
    localparam logic [CNT_W-1:0] C_OHPRE = CNT_W'(OH_BITS - 1);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic strobe;
        logic frame;
        logic line_bit;
        e3oi_oh_bit_t pend_a;
        e3oi_oh_bit_t pend_n;
        e3oi_oh_bit_t act_a;
        e3oi_oh_bit_t act_n;
    } e3oi_state_t;

    e3oi_state_t st_q;
    e3oi_state_t st_d;
    e3oi_te_in_t te;
    logic [SYNC_W-1:0] te_raw;
    logic [SYNC_W-1:0] te_sync;
    logic tick;
    logic [CNT_W-1:0] nxt;

    // the slot before each overhead position, including the last bit before position 0
    function automatic logic strobe_slot(input logic [CNT_W-1:0] c);
        return (c == LAST) || (c < C_OHPRE);
    endfunction : strobe_slot

    // the two ticks are enables on this clock, so no crossing is needed here
    assign tick = use_recovered_clock ? receive_recovered_clock : transmit_line_clock;

    assign te_raw = {overhead_insert_request, overhead_bit_in};

    e3oi_pin_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .pin_in(te_raw),
        .pin_out(te_sync)
    );

    assign te = te_sync;

    always_comb begin
        st_d = st_q;
        nxt = (st_q.cnt == LAST) ? '0 : st_q.cnt + CNT_W'(1);
        if (tick) begin
            st_d.cnt = nxt;
            // strobe covers the bit period just before an overhead slot
            st_d.strobe = strobe_slot(nxt);
            st_d.frame = (nxt == LAST);
            st_d.line_bit = core_bit;
            if (st_q.cnt == C_A && st_q.act_a.valid) begin
                st_d.line_bit = st_q.act_a.val;
            end else if (st_q.cnt == C_N && st_q.act_n.valid) begin
                st_d.line_bit = st_q.act_n.val;
            end
            // capture at the end of the slot, well after the request has settled;
            // alignment slots never reach these branches, so such requests drop
            if (te.ins && st_q.cnt == C_A) begin
                st_d.pend_a = '{valid: 1'b1, val: te.bit_val};
            end else if (te.ins && st_q.cnt == C_N) begin
                st_d.pend_n = '{valid: 1'b1, val: te.bit_val};
            end
            if (st_q.cnt == LAST) begin
                st_d.act_a = st_q.pend_a;
                st_d.act_n = st_q.pend_n;
                st_d.pend_a = '0;
                st_d.pend_n = '0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tx_line_bit = st_q.line_bit;
    assign overhead_slot_strobe = st_q.strobe;
    assign overhead_frame_marker = st_q.frame;

    AST_STEP_ON_TICK: assert property (@(posedge clock) disable iff (rst)
        !tick |=> $stable(st_q.cnt))
        else $error("bit counter moved without a tick");

    AST_STROBE_SLOT: assert property (@(posedge clock) disable iff (rst)
        overhead_slot_strobe |-> strobe_slot(st_q.cnt))
        else $error("strobe outside the bit before an overhead slot");

    AST_MARKER_LAST: assert property (@(posedge clock) disable iff (rst)
        tick && st_q.cnt == LAST - CNT_W'(1) |=> overhead_frame_marker)
        else $error("frame marker missing on last bit");

    AST_MARKER_WITH_STROBE: assert property (@(posedge clock) disable iff (rst)
        overhead_frame_marker |-> overhead_slot_strobe)
        else $error("frame marker without strobe");

    AST_CAPTURE_A: assert property (@(posedge clock) disable iff (rst)
        tick && st_q.cnt == C_A && te.ins |=>
            st_q.pend_a.valid && st_q.pend_a.val == $past(te.bit_val))
        else $error("A bit not captured");

    AST_IGNORE_A: assert property (@(posedge clock) disable iff (rst)
        tick && st_q.cnt == C_A && !te.ins |=> !st_q.pend_a.valid)
        else $error("A bit captured without request");

    // sampled rst skips the release edge, where a tick meets a state still held cleared
    AST_FAS_KEPT: assert property (@(posedge clock) disable iff (rst)
        !rst && tick && st_q.cnt < C_FAS |=> tx_line_bit == $past(core_bit))
        else $error("alignment bit altered");

    AST_NEXT_FRAME: assert property (@(posedge clock) disable iff (rst)
        tick && st_q.cnt == LAST |=> st_q.act_n == $past(st_q.pend_n) && !st_q.pend_n.valid)
        else $error("pending N bit not moved to next frame");

    AST_N_OUT: assert property (@(posedge clock) disable iff (rst)
        tick && st_q.cnt == C_N && !st_q.act_n.valid |=> tx_line_bit == $past(core_bit))
        else $error("N slot lost its internal value");

    AST_STROBE_EXACT: assert property (@(posedge clock) disable iff (rst)
        !rst && tick |=> overhead_slot_strobe == strobe_slot(st_q.cnt))
        else $error("strobe missing before an overhead slot");

    AST_STROBE_HOLD: assert property (@(posedge clock) disable iff (rst)
        !tick |=> $stable(overhead_slot_strobe))
        else $error("strobe changed inside a bit period");

    AST_MARKER_ONLY_LAST: assert property (@(posedge clock) disable iff (rst)
        overhead_frame_marker |-> st_q.cnt == LAST)
        else $error("frame marker away from the last bit");

    AST_MARKER_HOLD: assert property (@(posedge clock) disable iff (rst)
        !tick |=> $stable(overhead_frame_marker))
        else $error("frame marker changed inside a bit period");

    AST_CAPTURE_N: assert property (@(posedge clock) disable iff (rst)
        tick && st_q.cnt == C_N && te.ins |=>
            st_q.pend_n.valid && st_q.pend_n.val == $past(te.bit_val))
        else $error("N bit not captured");

    AST_IGNORE_N: assert property (@(posedge clock) disable iff (rst)
        tick && st_q.cnt == C_N && !te.ins |=> !st_q.pend_n.valid)
        else $error("N bit captured without request");

    AST_FAS_NO_PEND: assert property (@(posedge clock) disable iff (rst)
        tick && st_q.cnt < C_FAS && te.ins |=> $stable(st_q.pend_a) && $stable(st_q.pend_n))
        else $error("request in an alignment slot was taken");

    AST_NEXT_FRAME_A: assert property (@(posedge clock) disable iff (rst)
        tick && st_q.cnt == LAST |=> st_q.act_a == $past(st_q.pend_a) && !st_q.pend_a.valid)
        else $error("pending A bit not moved to next frame");

    AST_A_OUT: assert property (@(posedge clock) disable iff (rst)
        tick && st_q.cnt == C_A && st_q.act_a.valid |=> tx_line_bit == $past(st_q.act_a.val))
        else $error("accepted A bit not sent");

    AST_N_INS_OUT: assert property (@(posedge clock) disable iff (rst)
        tick && st_q.cnt == C_N && st_q.act_n.valid |=> tx_line_bit == $past(st_q.act_n.val))
        else $error("accepted N bit not sent");

    AST_PEND_A_KEEP: assert property (@(posedge clock) disable iff (rst)
        st_q.cnt != C_A && st_q.cnt != LAST |=> $stable(st_q.pend_a))
        else $error("pending A bit changed outside its slot");

    AST_ACT_A_KEEP: assert property (@(posedge clock) disable iff (rst)
        !(tick && st_q.cnt == LAST) |=> $stable(st_q.act_a))
        else $error("active A bit changed inside a frame");

    AST_A_OWN: assert property (@(posedge clock) disable iff (rst)
        !rst && tick && st_q.cnt == C_A && !st_q.act_a.valid |=> tx_line_bit == $past(core_bit))
        else $error("A slot lost its internal value");

    AST_TAIL_OWN: assert property (@(posedge clock) disable iff (rst)
        !rst && tick && st_q.cnt > C_N |=> tx_line_bit == $past(core_bit))
        else $error("bit after the overhead altered");

    AST_LINE_HOLD: assert property (@(posedge clock) disable iff (rst)
        !tick |=> $stable(tx_line_bit))
        else $error("line bit changed without a tick");

    AST_WRAP: assert property (@(posedge clock) disable iff (rst)
        tick && st_q.cnt == LAST |=> st_q.cnt == '0)
        else $error("bit counter did not wrap after the last bit");

    AST_COUNT_STEP: assert property (@(posedge clock) disable iff (rst)
        !rst && tick && st_q.cnt != LAST |=> st_q.cnt == $past(st_q.cnt) + CNT_W'(1))
        else $error("bit counter did not step by one");
endmodule : e3oi_tx_overhead

// ---- sim/e3oi_te_model.sv ----
`timescale 1ns/1ps
module e3oi_te_model (
    // clock, reset and bit tick
    input wire logic clock,
    input wire logic rst,
    input wire logic tick,
    // framer outputs
    input wire logic strobe,
    input wire logic marker,
    // insertion order from the bench
    input wire logic ins_en,
    input wire logic [3:0] ins_pos,
    input wire logic ins_val,
    input wire logic ins_req,
    // pins into the framer
    output logic oh_bit,
    output logic oh_req
);
    logic [3:0] cnt_q;
    logic act_q;
    logic [3:0] cnt_d;
    logic act_d;
    always_comb begin
        cnt_d = marker ? 4'h0 : cnt_q + 4'h1;
        act_d = marker ? ins_en : act_q;
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            act_q <= 1'b0;
            oh_bit <= 1'b0;
            oh_req <= 1'b0;
        end else if (tick && strobe) begin
            cnt_q <= cnt_d;
            act_q <= act_d;
            oh_req <= act_d && cnt_d == ins_pos && ins_req;
            // released data line shows the inverse, never a stale value
            oh_bit <= (act_d && cnt_d == ins_pos) ? ins_val : ~oh_bit;
        end
    end
endmodule : e3oi_te_model

// ---- sim/e3oi_tx_overhead_tb.sv ----
`timescale 1ns/1ps
module e3oi_tx_overhead_tb;
    import e3oi_pkg::*;
    localparam int FB = 24;
    logic clock = 0, rst = 1, tlc = 0, rrc = 0, use_rec = 0, core_bit = 0;
    logic en = 0, val = 0, req = 0, seen = 0;
    logic [3:0] pos = 4'h0;
    logic tx_line_bit, strobe, marker, oh_bit, oh_req, tick;
    int fail_count = 0, check_count = 0, diff = 0, ph = 0, nstb = 0, nbit = 0;
    always #10 clock = ~clock;
    assign tick = use_rec ? rrc : tlc;
    e3oi_tx_overhead #(.FRAME_BITS(FB)) i_dut (.clock(clock), .rst(rst),
        .transmit_line_clock(tlc), .receive_recovered_clock(rrc),
        .use_recovered_clock(use_rec), .core_bit(core_bit), .tx_line_bit(tx_line_bit),
        .overhead_bit_in(oh_bit), .overhead_insert_request(oh_req),
        .overhead_slot_strobe(strobe), .overhead_frame_marker(marker));
    e3oi_te_model i_te (.clock(clock), .rst(rst), .tick(tick), .strobe(strobe),
        .marker(marker), .ins_en(en), .ins_pos(pos), .ins_val(val), .ins_req(req),
        .oh_bit(oh_bit), .oh_req(oh_req));
    task automatic check(string what, int exp, int got);
        check_count++;
        if (exp != got) begin
            fail_count++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check
    task automatic report_and_stop;
        if (fail_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    // ticks every 6 and 7 clocks, both above the 5-clock settling need
    always @(posedge clock) begin
        ph <= (ph == 41) ? 0 : ph + 1;
        tlc <= (ph % 6) == 0;
        rrc <= (ph % 7) == 3;
        if (rst) seen <= 1'b0;
        else if (tick) begin
            nbit <= nbit + 1;
            nstb <= nstb + (strobe === 1'b1);
            diff <= diff + (tx_line_bit !== core_bit);
            if (marker === 1'b1) begin
                check("strobe at marker", 1, strobe === 1'b1);
                if (seen) check("bits per frame", FB, nbit);
                if (seen) check("strobes per frame", OH_BITS, nstb);
                seen <= 1'b1;
                nbit <= 1;
                nstb <= 1;
            end
        end
    end
    task automatic wait_frames(int n);
        repeat (n) begin
            @(posedge clock);
            while (!(tick && marker === 1'b1)) @(posedge clock);
        end
    endtask : wait_frames
    task automatic run(string what, logic c, logic [3:0] p, logic v, logic r, int k, int exp);
        int base;
        core_bit <= c;
        pos <= p;
        val <= v;
        req <= r;
        wait_frames(2);
        base = diff;
        en <= 1'b1;
        wait_frames(k);
        en <= 1'b0;
        wait_frames(1);
        check({what, " next frame"}, (exp > 0) ? exp - 1 : 0, diff - base);
        wait_frames(2);
        check(what, exp, diff - base);
    endtask : run
    task automatic t_a_one; run("a bit", 1'b0, 4'hA, 1'b1, 1'b1, 2, 2); endtask : t_a_one
    task automatic t_n_one; run("n bit", 1'b0, 4'hB, 1'b1, 1'b1, 1, 1); endtask : t_n_one
    task automatic t_fas; run("align slot", 1'b0, 4'h5, 1'b1, 1'b1, 2, 0); endtask : t_fas
    task automatic t_no_req; run("req low", 1'b0, 4'hA, 1'b1, 1'b0, 2, 0); endtask : t_no_req
    task automatic t_core; run("core kept", 1'b1, 4'hA, 1'b0, 1'b1, 1, 1); endtask : t_core
    task automatic t_rec; run("recovered", 1'b0, 4'hB, 1'b1, 1'b1, 1, 1); endtask : t_rec
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_a_one();
        t_n_one();
        t_fas();
        t_no_req();
        t_core();
        // clock source only changes under reset so no short bit period occurs
        rst <= 1'b1;
        use_rec <= 1'b1;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_rec();
        report_and_stop();
    end
    initial begin
        repeat (30000) @(posedge clock);
        fail_count++;
        report_and_stop();
    end
endmodule : e3oi_tx_overhead_tb
